//--- logic/spi_slave_transaction_guard.v
// Serial slave register port with transaction length and timeout guard.
// Assumes an external register file answering o_reg_addr combinationally,
// and pins asynchronous to i_core_clk.
`timescale 1ns/100ps
`include "spi_guard_defines.vh"
module spi_slave_transaction_guard #(
    parameter [19:0] TIMEOUT_CYC = `TIMEOUT_CYCLES,
    parameter [19:0] START_CYC = `START_LOW_CYCLES
) (
    input wire i_core_clk,
    input wire i_rst,
    input wire i_mode_three_wire,
    input wire i_cs_n,
    input wire i_sclk,
    input wire i_sdi,
    output reg o_sdo,
    output wire o_sdo_oe,
    input wire [1:0] i_checksum_fault_bits,
    input wire [13:0] i_irq_causes,
    output reg [6:0] o_reg_addr,
    output reg [15:0] o_reg_wdata,
    output reg o_reg_wr,
    input wire i_reg_addr_valid,
    input wire [15:0] i_reg_rdata,
    output reg o_flag_read,
    output reg o_soft_reset,
    output reg [15:0] o_last_transfer_word,
    output wire o_timeout
);
    wire cs_n_s;
    wire sclk_s;
    wire sdi_s;
    reg sclk_d;
    reg cs_n_d;
    reg active;
    reg timed_out;
    reg is_read;
    reg load_pending;
    reg write_ready;
    reg [4:0] clk_cnt;
    reg [22:0] shift_in;
    reg [15:0] out_shift;
    reg [15:0] read_word;
    reg [19:0] idle_cnt;
    reg [19:0] low_cnt;

    sync_2ff u_sync_cs (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_async(i_cs_n),
        .o_sync(cs_n_s)
    );
    sync_2ff u_sync_sclk (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_async(i_sclk),
        .o_sync(sclk_s)
    );
    sync_2ff u_sync_sdi (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_async(i_sdi),
        .o_sync(sdi_s)
    );

    // Read value of an address; own registers first, then the register file
    function [15:0] read_mux;
        input [6:0] addr;
        input valid;
        input [15:0] ext;
        input [15:0] flags;
        input [15:0] last;
        begin
            if (addr == `ADDR_SYSTEM_FLAG) begin
                read_mux = flags;
            end else if (addr == `ADDR_LAST_WORD) begin
                read_mux = last;
            end else if (addr == `ADDR_RESTART) begin
                read_mux = 16'h0000;
            end else if (valid) begin
                read_mux = ext;
            end else begin
                read_mux = 16'h0000;
            end
        end
    endfunction

    wire sclk_rise = sclk_s & ~sclk_d;
    wire sclk_fall = ~sclk_s & sclk_d;
    // Mode chosen by strap, edges found by oversampling
    wire cs_fall = ~i_mode_three_wire & ~cs_n_s & cs_n_d;
    wire cs_rise = ~i_mode_three_wire & cs_n_s & ~cs_n_d;
    // Three-wire start after long low clock
    wire low_start = i_mode_three_wire & ~sclk_s & (low_cnt == START_CYC - 20'h0_0001);
    // Three-wire start ignored until 24 clocks seen, unless idle or timed out
    wire start = cs_fall | (low_start & (~active | timed_out | (clk_cnt >= `FRAME_CLOCKS)));
    wire frame_end = cs_rise | start;
    // Count only while live and not timed out
    wire counting = active & ~timed_out & (i_mode_three_wire | ~cs_n_s);
    wire [15:0] flag_word = {i_checksum_fault_bits, i_irq_causes};

    // Output driven during a read while the clock count is 8 to 24, past the last data bit
    assign o_sdo_oe = active & ~timed_out & is_read & (clk_cnt >= `ADDR_CLOCKS)
        & (clk_cnt <= `FRAME_CLOCKS) & (i_mode_three_wire | ~cs_n_s);
    assign o_timeout = timed_out;

    always @(posedge i_core_clk) begin
        if (i_rst) begin
            sclk_d <= 1'b1;
            cs_n_d <= 1'b1;
            low_cnt <= 20'h0_0000;
        end else begin
            sclk_d <= sclk_s;
            cs_n_d <= cs_n_s;
            if (sclk_s) begin
                low_cnt <= 20'h0_0000;
            end else if (low_cnt != 20'hF_FFFF) begin
                low_cnt <= low_cnt + 20'h0_0001;
            end
        end
    end

    always @(posedge i_core_clk) begin
        if (i_rst) begin
            active <= 1'b0;
            timed_out <= 1'b0;
            is_read <= 1'b0;
            load_pending <= 1'b0;
            write_ready <= 1'b0;
            clk_cnt <= 5'h00;
            shift_in <= 23'h00_0000;
            out_shift <= 16'h0000;
            read_word <= 16'h0000;
            idle_cnt <= 20'h0_0000;
            o_sdo <= 1'b0;
            o_reg_addr <= 7'h00;
            o_reg_wdata <= 16'h0000;
            o_reg_wr <= 1'b0;
            o_flag_read <= 1'b0;
            o_soft_reset <= 1'b0;
            o_last_transfer_word <= `LAST_WORD_RESET;
        end else begin
            o_reg_wr <= 1'b0;
            o_flag_read <= 1'b0;
            o_soft_reset <= 1'b0;
            // Commit only with exactly 24 clocks
            if (frame_end & active & write_ready & ~timed_out
                    & (clk_cnt == `FRAME_CLOCKS)) begin
                if (o_reg_addr == `ADDR_RESTART) begin
                    if (o_reg_wdata == `RESTART_KEY) begin
                        o_soft_reset <= 1'b1;
                        o_last_transfer_word <= `LAST_WORD_RESET;
                    end else begin
                        o_last_transfer_word <= o_reg_wdata;
                    end
                end else if (o_reg_addr != `ADDR_SYSTEM_FLAG
                        && o_reg_addr != `ADDR_LAST_WORD && i_reg_addr_valid) begin
                    o_reg_wr <= 1'b1;
                    o_last_transfer_word <= o_reg_wdata;
                end
            end
            if (start) begin
                active <= 1'b1;
                timed_out <= 1'b0;
                clk_cnt <= 5'h00;
                idle_cnt <= 20'h0_0000;
                write_ready <= 1'b0;
                load_pending <= 1'b0;
                is_read <= 1'b0;
            end else if (cs_rise) begin
                active <= 1'b0;
            end else if (active & ~timed_out) begin
                if (sclk_rise | sclk_fall) begin
                    idle_cnt <= 20'h0_0000;
                end else if (idle_cnt == TIMEOUT_CYC - 20'h0_0001) begin
                    timed_out <= 1'b1;
                end else begin
                    idle_cnt <= idle_cnt + 20'h0_0001;
                end
                if (counting & sclk_rise) begin
                    if (clk_cnt != `CLOCK_SAT) begin
                        clk_cnt <= clk_cnt + 5'h01;
                    end
                    if (clk_cnt < `FRAME_CLOCKS) begin
                        shift_in <= {shift_in[21:0], sdi_s};
                    end
                    if (clk_cnt == `ADDR_CLOCKS - 5'h01) begin
                        is_read <= shift_in[6];
                        o_reg_addr <= {shift_in[5:0], sdi_s};
                        load_pending <= shift_in[6];
                    end
                    if (clk_cnt == `FRAME_CLOCKS - 5'h01) begin
                        if (is_read) begin
                            // Read reaching 24 clocks is normal
                            o_last_transfer_word <= read_word;
                            o_flag_read <= (o_reg_addr == `ADDR_SYSTEM_FLAG);
                        end else begin
                            o_reg_wdata <= {shift_in[14:0], sdi_s};
                            write_ready <= 1'b1;
                        end
                    end
                end
                if (load_pending) begin
                    read_word <= read_mux(o_reg_addr, i_reg_addr_valid, i_reg_rdata,
                        flag_word, o_last_transfer_word);
                    out_shift <= read_mux(o_reg_addr, i_reg_addr_valid, i_reg_rdata,
                        flag_word, o_last_transfer_word);
                    load_pending <= 1'b0;
                end
                if (counting & sclk_fall & is_read & (clk_cnt >= `ADDR_CLOCKS)
                        & (clk_cnt < `FRAME_CLOCKS)) begin
                    o_sdo <= out_shift[15];
                    out_shift <= {out_shift[14:0], 1'b0};
                end
            end
        end
    end
endmodule // spi_slave_transaction_guard

//--- logic/spi_guard_defines.vh
// Constants for the guarded serial register-access port.
// Assumes a 125 MHz core clock; included by its bare name.
// What this block does
// - Abort any transfer after 6 ms without a serial clock toggle, both modes.
// - A transaction with more than 24 clocks never performs its write.
// - Reads longer than 24 clocks complete using only the first 24 clocks.
// - Reads of an unmapped address return an all-zero word.
// - Writes to an unmapped address are dropped, nothing changes.
// - Four-wire: read needs 24 clocks; write exactly 24, no timeout, to update.
// - Three-wire: read reaching 24 clocks is normal; write exactly 24, no timeout.
// - Count clocks while select low or between starts; stop at timeout.
// - Three-wire: short transaction absorbs next clocks; never below 24.
// - Writing 789AH to address 00H performs a full software reset.
// - Checksum fault bits are readable in the system flag register 01H.
// - Every interrupt cause is readable in the system flag register 01H.
// - Host picks three- or four-wire mode; slow isolated clocks are fine.
// - Sample input on rising clock, drive output on falling clock.
// - Frame: access bit (1 read), 7-bit address, 16 data bits.
// - Three-wire start: clock held low at least 400 us.
// - Address 06H holds the last word of a successful transfer, read-only.
`ifndef SPI_GUARD_DEFINES_VH
`define SPI_GUARD_DEFINES_VH

// Core-clock counts for 6 ms of idle clock and a 400 us start, at 125 MHz
`define TIMEOUT_CYCLES 20'hB_71B0
`define START_LOW_CYCLES 20'h0_C350
`define FRAME_CLOCKS 5'h18
`define ADDR_CLOCKS 5'h08
`define CLOCK_SAT 5'h19

`define ADDR_RESTART 7'h00
`define ADDR_SYSTEM_FLAG 7'h01
`define ADDR_LAST_WORD 7'h06
`define RESTART_KEY 16'h789A
`define LAST_WORD_RESET 16'h0000

`endif

//--- logic/sync_2ff.v
// Two-flop level synchroniser for one pin.
// Assumes the pin is asynchronous to i_core_clk.
`timescale 1ns/100ps
module sync_2ff (
    input wire i_core_clk,
    input wire i_rst,
    input wire i_async,
    output reg o_sync
);
    reg meta;

    always @(posedge i_core_clk) begin
        if (i_rst) begin
            // Select and clock pins idle high; no false edge after reset
            meta <= 1'b1;
            o_sync <= 1'b1;
        end else begin
            meta <= i_async;
            o_sync <= meta;
        end
    end
endmodule // sync_2ff

//--- tb/spi_guard_props.sv
// Port checker for the guarded serial register port.
// Assumes the host clock stays well above the core clock period.
`timescale 1ns/100ps
module spi_guard_props #(
    parameter [19:0] TIMEOUT_CYC = 20'hB_71B0
) (
    input wire i_core_clk,
    input wire i_rst,
    input wire i_mode_three_wire,
    input wire i_cs_n,
    input wire i_sclk,
    input wire o_sdo,
    input wire o_sdo_oe,
    input wire [6:0] o_reg_addr,
    input wire [15:0] o_reg_wdata,
    input wire o_reg_wr,
    input wire i_reg_addr_valid,
    input wire o_flag_read,
    input wire o_soft_reset,
    input wire [15:0] o_last_transfer_word,
    input wire o_timeout
);
    reg [19:0] idle;
    reg sclk_q;
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    // Pin-level idle count; the design sees the pin two cycles late
    always @(posedge i_core_clk) begin
        sclk_q <= i_sclk;
        idle <= (i_rst || i_sclk != sclk_q) ? 20'h0 : idle + 20'h1;
    end
    a_timeout_after_idle: assert property ($rose(o_timeout) |-> idle >= TIMEOUT_CYC - 20'h4)
        else $error("timeout raised while the serial clock was active");
    a_timeout_no_oe: assert property (o_timeout |-> !o_sdo_oe)
        else $error("data out enabled after timeout");
    a_wr_single: assert property (o_reg_wr |=> !o_reg_wr)
        else $error("write strobe longer than one cycle");
    a_wr_clean_target: assert property (o_reg_wr |-> !o_timeout && i_reg_addr_valid
        && o_reg_addr != 7'h01 && o_reg_addr != 7'h06)
        else $error("write committed to a bad target");
    a_wr_last_word: assert property (o_reg_wr && o_reg_addr != 7'h00
        |-> ##[0:1] o_last_transfer_word == o_reg_wdata)
        else $error("last word not updated by write");
    a_soft_key_only: assert property (o_soft_reset |-> o_reg_addr == 7'h00
        && o_reg_wdata == 16'h789A)
        else $error("restart without key");
    a_soft_clears: assert property (o_soft_reset |-> ##[0:1] o_last_transfer_word == 16'h0)
        else $error("restart left last word");
    a_flag_read_addr: assert property (o_flag_read |-> o_reg_addr == 7'h01)
        else $error("flag read pulse for wrong address");
    a_sdo_on_fall: assert property ($changed(o_sdo) |-> !i_sclk)
        else $error("data out moved while serial clock high");
    a_oe_needs_select: assert property (!i_mode_three_wire && i_cs_n [*4] |-> !o_sdo_oe)
        else $error("data out enabled without select");
    c_write: cover property (o_reg_wr);
    c_restart: cover property (o_soft_reset);
    c_timeout: cover property ($rose(o_timeout));
endmodule // spi_guard_props
bind spi_slave_transaction_guard spi_guard_props #(.TIMEOUT_CYC(TIMEOUT_CYC)) spi_guard_props_inst (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_mode_three_wire(i_mode_three_wire),
    .i_cs_n(i_cs_n), .i_sclk(i_sclk), .o_sdo(o_sdo), .o_sdo_oe(o_sdo_oe),
    .o_reg_addr(o_reg_addr), .o_reg_wdata(o_reg_wdata), .o_reg_wr(o_reg_wr),
    .i_reg_addr_valid(i_reg_addr_valid), .o_flag_read(o_flag_read),
    .o_soft_reset(o_soft_reset), .o_last_transfer_word(o_last_transfer_word),
    .o_timeout(o_timeout));

//--- tb/spi_host_model.sv
// Host side of the serial link: select, clock and data in.
// Assumes the core clock as time base, five cycles a half period (80 ns clock).
`timescale 1ns/100ps
module spi_host_model #(
    parameter int START_LOW = 50
) (
    input wire i_core_clk,
    input wire i_sdo,
    output reg o_cs_n,
    output reg o_sclk,
    output reg o_sdi
);
    initial begin
        o_cs_n = 1'b1;
        o_sclk = 1'b1;
        o_sdi = 1'b1;
    end
    task automatic frame(input bit three, input bit [23:0] bits, input int n, input int hold,
                         output logic [15:0] rd);
        int i;
        rd = 16'h0;
        @(negedge i_core_clk) o_cs_n <= 1'b0;
        repeat (5) @(negedge i_core_clk);
        for (i = 0; i < n; i++) begin
            o_sclk <= 1'b0;
            o_sdi <= (i < 24) ? bits[23 - i] : ~o_sdi;
            repeat ((three && i == 0) ? START_LOW : 5) @(negedge i_core_clk);
            o_sclk <= 1'b1;
            if (i >= 8 && i < 24) rd = {rd[14:0], i_sdo};
            repeat (5) @(negedge i_core_clk);
        end
        // Released data line shows the inverse, never a stale bit
        o_sdi <= ~o_sdi;
        repeat (hold) @(negedge i_core_clk);
        if (!three) o_cs_n <= 1'b1;
        repeat (5) @(negedge i_core_clk);
    endtask
endmodule // spi_host_model

//--- tb/tb_top.sv
// Self-checking bench for the guarded serial register port.
// Assumes the host model and a small register file kept here.
`timescale 1ns/100ps
module tb_top;
    logic clk = 0, rst = 1, mode3 = 0, sdo, oe, wr, fr, sr, tmo, av, to_q = 0;
    logic cs_n, sclk, sdi;
    logic [1:0] ck = 0;
    logic [13:0] irq = 0;
    logic [6:0] ad;
    logic [15:0] wd, lw, r0, r1, rd;
    logic [23:0] exp_q[$];
    int fails = 0, n_checks = 0, n_to = 0, n_fr = 0;
    always #4 clk = ~clk;
    function automatic logic [15:0] ext(input logic [6:0] a);
        return {a, 9'h0} ^ 16'h5A5A;
    endfunction
    assign av = ad <= 7'h01 || ad == 7'h06 || (ad >= 7'h20 && ad <= 7'h2C);
    spi_host_model spi_host_model_inst (.i_core_clk(clk), .i_sdo(sdo), .o_cs_n(cs_n),
        .o_sclk(sclk), .o_sdi(sdi));
    spi_slave_transaction_guard #(.TIMEOUT_CYC(20'hC8), .START_CYC(20'h28))
        spi_slave_transaction_guard_inst (.i_core_clk(clk), .i_rst(rst),
        .i_mode_three_wire(mode3), .i_cs_n(cs_n), .i_sclk(sclk), .i_sdi(sdi), .o_sdo(sdo),
        .o_sdo_oe(oe), .i_checksum_fault_bits(ck), .i_irq_causes(irq), .o_reg_addr(ad),
        .o_reg_wdata(wd), .o_reg_wr(wr), .i_reg_addr_valid(av), .i_reg_rdata(ext(ad)),
        .o_flag_read(fr), .o_soft_reset(sr), .o_last_transfer_word(lw), .o_timeout(tmo));
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        n_checks++;
        if (seen !== want) begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Push before the frame: the commit can land before the host task returns
    task automatic op(input bit r, input logic [6:0] a, input logic [15:0] d, input int n = 24,
                      input int hold = 4, input int push = 0);
        if (push != 0) exp_q.push_back({push == 2, a, d});
        spi_host_model_inst.frame(mode3, {r, a, d}, n, hold, rd);
        if (r && n >= 24) check(rd, d);
        // Output stays enabled after a full three-wire read until the next start or a timeout
        check(oe, mode3 && r && n == 24);
    endtask
    always @(posedge clk) begin
        to_q <= tmo;
        if (tmo && !to_q) n_to++;
        if (fr) n_fr++;
        if (!rst && (wr || sr))
            check({sr, ad, wd}, exp_q.size() != 0 ? exp_q.pop_front() : 24'hFF_FFFF);
    end
    initial begin
        void'($urandom(32'hBBBD));
        r0 = 16'($urandom);
        r1 = 16'($urandom);
        repeat (5) @(posedge clk);
        @(negedge clk) rst = 0;
        repeat (4) @(negedge clk);
        check(lw, 16'h0);
        op(0, 7'h21, r0, 24, 4, 1);
        op(1, 7'h06, r0);
        op(0, 7'h21, r1, 25);
        op(0, 7'h21, r1, 23);
        op(0, 7'h10, r1);
        op(0, 7'h06, r1);
        op(1, 7'h06, r0);
        op(1, 7'h10, 16'h0);
        op(1, 7'h25, ext(7'h25), 30);
        op(1, 7'h22, 16'h0, 16);
        op(1, 7'h06, ext(7'h25));
        ck = 2'($urandom);
        irq = 14'($urandom);
        op(1, 7'h01, {ck, irq});
        check(n_fr, 1);
        op(0, 7'h21, r1, 24, 250);
        check(n_to, 1);
        op(0, 7'h00, 16'h789A, 24, 4, 2);
        op(1, 7'h06, 16'h0);
        mode3 = 1;
        op(0, 7'h22, r1, 24, 4, 1);
        op(1, 7'h06, r1);
        op(0, 7'h23, r0, 20);
        op(0, 7'h24, r0);
        op(1, 7'h06, r1);
        repeat (20) @(negedge clk);
        check(exp_q.size(), 0);
        end_of_test;
    end
    initial begin
        repeat (60000) @(posedge clk);
        fails++;
        end_of_test;
    end
endmodule // tb_top
